// file: core/aux_status_pkg.sv
// Constants, field layouts and enumerations of the auxiliary status bank.
package aux_status_pkg;

    // ------------------------------------------------------------
    // Register indexes and byte addresses
    // ------------------------------------------------------------
    localparam int IDX_SERIAL_RX = 'h09;
    localparam int IDX_AUX_RX = 'h0a;
    localparam int IDX_RANGE = 'h0b;
    localparam int IDX_CASSETTE = 'h0d;
    localparam logic [7:0] ADDR_SERIAL_RX = 8'(4 * IDX_SERIAL_RX);
    localparam logic [7:0] ADDR_AUX_RX = 8'(4 * IDX_AUX_RX);
    localparam logic [7:0] ADDR_RANGE = 8'(4 * IDX_RANGE);
    localparam logic [7:0] ADDR_CASSETTE = 8'(4 * IDX_CASSETTE);
    localparam logic [7:0] ADDR_PORT_CTRL = 8'h40;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h44;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h48;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int RX_DIGITS = 4;
    localparam int RANGE_COUNT = 8;
    localparam int PULSE_BIT = 15;
    localparam int CAS_PRESENT_BIT = 0;
    localparam int CAS_CLOCK_BIT = 1;
    localparam int CAS_PROTECT_BIT = 2;
    localparam int CAS_TYPE_LSB = 4;
    localparam int CTRL_SER_MODE_LSB = 0;
    localparam int CTRL_AUX_MODE_LSB = 2;
    localparam int CTRL_CLR_SER_BIT = 8;
    localparam int CTRL_CLR_AUX_BIT = 9;
    localparam int CTRL_CLR_OVF_BIT = 10;
    localparam int CTRL_OVF_FLAG_BIT = 16;
    localparam int IRQ_SER_RX = 0;
    localparam int IRQ_AUX_RX = 1;
    localparam int IRQ_AUX_OVF = 2;
    localparam int IRQ_RANGE = 3;
    localparam int IRQ_PULSE = 4;
    localparam int IRQ_WIDTH = 5;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 5'h00;
    localparam logic [2:0] STRAP_WAIT_CYCLES = 3'h3;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_HOST_LINK = 2'b01,
        MODE_SERIAL = 2'b10,
        MODE_SPARE = 2'b11
    } port_mode_e;

    typedef enum logic [3:0] {
        CAS_NONE = 4'h0,
        CAS_EEPROM_4K = 4'h1,
        CAS_EEPROM_8K = 4'h2,
        CAS_FLASH_16K = 4'h3,
        CAS_EPROM = 4'h4
    } cassette_type_e;

    typedef enum logic [0:0] {
        CAP_WAIT = 1'b0,
        CAP_DONE = 1'b1
    } capture_state_e;

endpackage : aux_status_pkg

// file: core/level_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // Only the second stage reads the first one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : level_sync
`default_nettype wire

// file: core/bcd_counter.sv
// Decimal counter of several digits with synchronous clear.
`timescale 1ns/1ns
`default_nettype none
module bcd_counter #(
    parameter int DIGITS = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clear,
    input wire logic inc,
    // Count
    output logic [4*DIGITS-1:0] count
);

    logic [4*DIGITS-1:0] next_count;

    always_comb begin
        logic carry;
        carry = inc;
        next_count = count;
        for (int i = 0; i < DIGITS; i++) begin
            if (carry) begin
                if (count[4*i +: 4] == 4'h9) begin
                    next_count[4*i +: 4] = 4'h0;
                end else begin
                    next_count[4*i +: 4] = count[4*i +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
    end

    // A byte that lands on the clearing cycle is still counted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clear) begin
            count <= {{(4*DIGITS-1){1'b0}}, inc};
        end else begin
            count <= next_count;
        end
    end

endmodule : bcd_counter
`default_nettype wire

// file: core/aux_status_word_bank.sv
// Auxiliary status word bank with APB slave and interrupt logic.
//
// Function
// - Serial port byte count kept as four BCD digits, counting in serial-command mode.
// - Auxiliary port byte count kept as four BCD digits, serial-command mode only.
// - Bit n of the counter word follows comparison range n+1 hit.
// - Bit 15 of the counter word shows pulse output running.
// - Cassette-present bit reflects detection captured at power-up only.
// - Clock-available bit set when the installed cassette carries a clock.
// - Write-protect set for protected EEPROM or flash, always for EPROM.
// - Cassette type code in bits 4 to 7, values 0 to 4.
// - Aux overflow flag only meaningful in host-link or serial-command mode.
`timescale 1ns/1ns
`default_nettype none
module aux_status_word_bank (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial port events
    input wire logic serial_rx_byte,
    input wire logic aux_rx_byte,
    input wire logic aux_rx_overflow,
    // High-speed counter and pulse output
    input wire logic [7:0] counter_range_hit,
    input wire logic pulse_active,
    // Memory cassette pins
    input wire logic cas_detect,
    input wire logic cas_clock,
    input wire logic cas_protect,
    input wire logic [3:0] cas_kind,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [15:0] serial_count;
    logic [15:0] aux_count;
    logic [7:0] range_flags;
    logic pulse_flag;
    logic [1:0] ser_mode;
    logic [1:0] aux_mode;
    logic aux_ovf;
    logic aux_ovf_valid;
    logic cas_present;
    logic cas_clock_avail;
    logic [3:0] cas_type;
    logic cas_protected;
    logic [6:0] cas_sync;
    logic [2:0] strap_wait;
    aux_status_pkg::capture_state_e cap_state;
    logic [aux_status_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [aux_status_pkg::IRQ_WIDTH-1:0] irq_mask;
    logic [aux_status_pkg::IRQ_WIDTH-1:0] irq_event;
    logic setup_phase;
    logic wr_access;
    logic addr_hit;
    logic addr_ro;
    logic [31:0] rd_value;
    logic ser_inc;
    logic aux_inc;
    logic clr_ser;
    logic clr_aux;
    logic clr_ovf;
    logic [15:0] range_word;
    logic [15:0] cassette_word;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite && addr_hit && !addr_ro;
    assign pready = 1'b1;

    always_comb begin
        addr_hit = 1'b1;
        addr_ro = 1'b0;
        case (paddr)
            aux_status_pkg::ADDR_SERIAL_RX,
            aux_status_pkg::ADDR_AUX_RX,
            aux_status_pkg::ADDR_RANGE,
            aux_status_pkg::ADDR_CASSETTE: addr_ro = 1'b1;
            aux_status_pkg::ADDR_PORT_CTRL,
            aux_status_pkg::ADDR_IRQ_STATUS,
            aux_status_pkg::ADDR_IRQ_MASK: addr_ro = 1'b0;
            default: addr_hit = 1'b0;
        endcase
    end

    // Writes to the status words are refused rather than silently lost.
    assign pslverr = psel && penable && (!addr_hit || (addr_ro && pwrite));

    assign clr_ser = wr_access && paddr == aux_status_pkg::ADDR_PORT_CTRL &&
        pwdata[aux_status_pkg::CTRL_CLR_SER_BIT];
    assign clr_aux = wr_access && paddr == aux_status_pkg::ADDR_PORT_CTRL &&
        pwdata[aux_status_pkg::CTRL_CLR_AUX_BIT];
    assign clr_ovf = wr_access && paddr == aux_status_pkg::ADDR_PORT_CTRL &&
        pwdata[aux_status_pkg::CTRL_CLR_OVF_BIT];

    // ------------------------------------------------------------
    // Port mode control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_mode <= aux_status_pkg::MODE_OFF;
            aux_mode <= aux_status_pkg::MODE_OFF;
        end else if (wr_access && paddr == aux_status_pkg::ADDR_PORT_CTRL) begin
            ser_mode <= pwdata[aux_status_pkg::CTRL_SER_MODE_LSB +: 2];
            aux_mode <= pwdata[aux_status_pkg::CTRL_AUX_MODE_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Reception counters
    // ------------------------------------------------------------
    assign ser_inc = serial_rx_byte && ser_mode == aux_status_pkg::MODE_SERIAL;
    assign aux_inc = aux_rx_byte && aux_mode == aux_status_pkg::MODE_SERIAL;

    bcd_counter #(
        .DIGITS(aux_status_pkg::RX_DIGITS)
    ) u_serial_count (
        .pclk(pclk),
        .presetn(presetn),
        .clear(clr_ser),
        .inc(ser_inc),
        .count(serial_count)
    );

    bcd_counter #(
        .DIGITS(aux_status_pkg::RX_DIGITS)
    ) u_aux_count (
        .pclk(pclk),
        .presetn(presetn),
        .clear(clr_aux),
        .inc(aux_inc),
        .count(aux_count)
    );

    // ------------------------------------------------------------
    // Auxiliary port overflow flag
    // ------------------------------------------------------------
    assign aux_ovf_valid = aux_mode == aux_status_pkg::MODE_HOST_LINK ||
        aux_mode == aux_status_pkg::MODE_SERIAL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_ovf <= 1'b0;
        end else if (aux_rx_overflow && aux_ovf_valid) begin
            aux_ovf <= 1'b1;
        end else if (clr_ovf) begin
            aux_ovf <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Counter range and pulse status
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_flags <= 8'h00;
            pulse_flag <= 1'b0;
        end else begin
            range_flags <= counter_range_hit;
            pulse_flag <= pulse_active;
        end
    end

    assign range_word = {pulse_flag, 7'h00, range_flags};

    // ------------------------------------------------------------
    // Memory cassette detection
    // ------------------------------------------------------------
    level_sync #(
        .WIDTH(7)
    ) u_cas_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({cas_kind, cas_protect, cas_clock, cas_detect}),
        .sync_out(cas_sync)
    );

    // Presence and type are caught once, after the synchroniser has filled,
    // so a cassette pulled at run time does not change the presence, clock or type bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_state <= aux_status_pkg::CAP_WAIT;
            strap_wait <= 3'h0;
            cas_present <= 1'b0;
            cas_clock_avail <= 1'b0;
            cas_type <= aux_status_pkg::CAS_NONE;
        end else begin
            case (cap_state)
                aux_status_pkg::CAP_WAIT: begin
                    strap_wait <= strap_wait + 3'h1;
                    if (strap_wait == aux_status_pkg::STRAP_WAIT_CYCLES) begin
                        cap_state <= aux_status_pkg::CAP_DONE;
                        cas_present <= cas_sync[0];
                        cas_clock_avail <= cas_sync[0] && cas_sync[1];
                        if (cas_sync[0] && cas_sync[6:3] <= 4'h4) begin
                            cas_type <= cas_sync[6:3];
                        end
                    end
                end
                aux_status_pkg::CAP_DONE: cap_state <= aux_status_pkg::CAP_DONE;
                default: cap_state <= aux_status_pkg::CAP_WAIT;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cas_protected <= 1'b0;
        end else begin
            case (cas_type)
                aux_status_pkg::CAS_EEPROM_4K,
                aux_status_pkg::CAS_EEPROM_8K,
                aux_status_pkg::CAS_FLASH_16K: cas_protected <= cas_sync[2];
                aux_status_pkg::CAS_EPROM: cas_protected <= 1'b1;
                default: cas_protected <= 1'b0;
            endcase
        end
    end

    assign cassette_word = {8'h00, cas_type, 1'b0, cas_protected,
        cas_clock_avail, cas_present};

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irq_event[aux_status_pkg::IRQ_SER_RX] = ser_inc;
    assign irq_event[aux_status_pkg::IRQ_AUX_RX] = aux_inc;
    assign irq_event[aux_status_pkg::IRQ_AUX_OVF] = aux_rx_overflow && aux_ovf_valid;
    assign irq_event[aux_status_pkg::IRQ_RANGE] = |(counter_range_hit & ~range_flags);
    assign irq_event[aux_status_pkg::IRQ_PULSE] = pulse_active && !pulse_flag;

    // An event on the clearing cycle keeps its bit set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (wr_access && paddr == aux_status_pkg::ADDR_IRQ_STATUS) begin
            irq_status <= (irq_status & ~pwdata[aux_status_pkg::IRQ_WIDTH-1:0]) |
                irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= aux_status_pkg::IRQ_MASK_RESET;
        end else if (wr_access && paddr == aux_status_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= pwdata[aux_status_pkg::IRQ_WIDTH-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rd_value = 32'h0000_0000;
        case (paddr)
            aux_status_pkg::ADDR_SERIAL_RX: rd_value[15:0] = serial_count;
            aux_status_pkg::ADDR_AUX_RX: rd_value[15:0] = aux_count;
            aux_status_pkg::ADDR_RANGE: rd_value[15:0] = range_word;
            aux_status_pkg::ADDR_CASSETTE: rd_value[15:0] = cassette_word;
            aux_status_pkg::ADDR_PORT_CTRL: begin
                rd_value[aux_status_pkg::CTRL_SER_MODE_LSB +: 2] = ser_mode;
                rd_value[aux_status_pkg::CTRL_AUX_MODE_LSB +: 2] = aux_mode;
                rd_value[aux_status_pkg::CTRL_OVF_FLAG_BIT] =
                    aux_ovf && aux_ovf_valid;
            end
            aux_status_pkg::ADDR_IRQ_STATUS:
                rd_value[aux_status_pkg::IRQ_WIDTH-1:0] = irq_status;
            aux_status_pkg::ADDR_IRQ_MASK:
                rd_value[aux_status_pkg::IRQ_WIDTH-1:0] = irq_mask;
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // Read data is taken in the setup cycle so it is ready with no wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= rd_value;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ser_byte_low;
        ser_inc && !clr_ser && serial_count[3:0] != 4'h9;
    endsequence

    sequence s_read_range;
        setup_phase && !pwrite && paddr == aux_status_pkg::ADDR_RANGE ##1
            psel && penable;
    endsequence

    sequence s_status_clear_event;
        wr_access && paddr == aux_status_pkg::ADDR_IRQ_STATUS &&
            pwdata[aux_status_pkg::IRQ_SER_RX] && ser_inc;
    endsequence

    a_serial_count_hold: assert property (
        (ser_mode != aux_status_pkg::MODE_SERIAL && !clr_ser)
            |=> $stable(serial_count))
        else $error("serial count moved outside serial-command mode");

    a_aux_count_hold: assert property (
        (aux_mode != aux_status_pkg::MODE_SERIAL && !clr_aux)
            |=> $stable(aux_count))
        else $error("aux count moved outside serial-command mode");

    a_bcd_step_low: assert property (
        s_ser_byte_low |=> serial_count[3:0] == $past(serial_count[3:0]) + 4'h1
            && serial_count[15:4] == $past(serial_count[15:4]))
        else $error("serial count did not step by one decimal unit");

    a_bcd_digits_legal: assert property (
        aux_count[3:0] <= 4'h9 && aux_count[7:4] <= 4'h9 &&
            aux_count[11:8] <= 4'h9 && aux_count[15:12] <= 4'h9)
        else $error("aux count holds a non-decimal digit");

    a_range_follow: assert property (
        ##1 range_flags == $past(counter_range_hit))
        else $error("range flags do not follow comparator hits");

    a_pulse_follow: assert property (
        $rose(pulse_active) |=> range_word[aux_status_pkg::PULSE_BIT])
        else $error("pulse status bit did not rise");

    a_range_read_zero: assert property (
        s_read_range |-> prdata[31:16] == 16'h0000 && prdata[14:8] == 7'h00)
        else $error("unused counter word bits read non-zero");

    a_present_frozen: assert property (
        cap_state == aux_status_pkg::CAP_DONE |=> $stable(cas_present))
        else $error("cassette present changed after power-up");

    a_clock_needs_cas: assert property (
        cas_clock_avail |-> cas_present)
        else $error("clock available without cassette");

    a_eprom_protect: assert property (
        cas_type == aux_status_pkg::CAS_EPROM |=> cas_protected)
        else $error("eprom cassette not shown as protected");

    a_type_legal: assert property (
        cas_type <= 4'h4 && (cas_type == 4'h0 || cas_present))
        else $error("cassette type code out of range");

    a_ovf_gated: assert property (
        (aux_rx_overflow && !aux_ovf_valid && !aux_ovf) |=> !aux_ovf)
        else $error("overflow flag set in an invalid port mode");

    a_set_beats_clear: assert property (
        s_status_clear_event |=> irq_status[aux_status_pkg::IRQ_SER_RX])
        else $error("event lost on its clearing cycle");

endmodule : aux_status_word_bank
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the auxiliary status word bank.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic serial_rx_byte = 1'b0;
    logic aux_rx_byte = 1'b0;
    logic aux_rx_overflow = 1'b0;
    logic [7:0] counter_range_hit = 8'h00;
    logic pulse_active = 1'b0;
    logic cas_detect = 1'b0;
    logic cas_clock = 1'b0;
    logic cas_protect = 1'b0;
    logic [3:0] cas_kind = 4'h0;
    // Each note is {compare data, expected error, expected data}.
    logic [33:0] exp_q[$];
    int n_mismatch = 0;
    int n_tests = 0;

    always #5 pclk = ~pclk;

    aux_status_word_bank dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .serial_rx_byte, .aux_rx_byte,
        .aux_rx_overflow, .counter_range_hit, .pulse_active,
        .cas_detect, .cas_clock, .cas_protect, .cas_kind, .irq
    );

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic fail(input string msg);
        n_mismatch++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail

    // ------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [33:0] e);
        int i;
        exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            fail("no ready");
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0, {2'b10, v});
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic err);
        apb(1'b1, a, d, {1'b0, err, 32'h0});
    endtask : wr

    // A strobe held high for n edges stands for n back-to-back events.
    task automatic strobe(input int which, input int n);
        @(posedge pclk);
        case (which)
            0: serial_rx_byte <= 1'b1;
            1: aux_rx_byte <= 1'b1;
            default: aux_rx_overflow <= 1'b1;
        endcase
        repeat (n) @(posedge pclk);
        serial_rx_byte <= 1'b0;
        aux_rx_byte <= 1'b0;
        aux_rx_overflow <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : strobe

    task automatic chk_irq(input logic v);
        #1;
        n_tests++;
        if (irq !== v)
            fail("interrupt level");
    endtask : chk_irq

    // Cassette pins stay still across reset so the capture sees them.
    task automatic power_up(input logic [3:0] k);
        @(posedge pclk);
        presetn <= 1'b0;
        cas_kind <= k;
        cas_detect <= (k != 4'h0);
        cas_clock <= 1'($urandom);
        cas_protect <= (k != 4'h0) & 1'($urandom);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : power_up

    function automatic logic [15:0] bcd(input int n);
        return {4'(n / 1000 % 10), 4'(n / 100 % 10), 4'(n / 10 % 10),
                4'(n % 10)};
    endfunction : bcd

    function automatic logic [31:0] cas_exp();
        return {24'h0, cas_kind, 1'b0,
                (cas_kind == 4'h4) | (cas_protect & cas_detect),
                cas_clock & cas_detect, cas_detect};
    endfunction : cas_exp

    // ------------------------------------------------------------
    // Response monitor
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        logic [33:0] e;
        if (presetn && psel && penable && pready) begin
            n_tests++;
            if (exp_q.size() == 0) begin
                fail("unexpected transfer");
            end else begin
                e = exp_q.pop_front();
                if (pslverr !== e[32] || (e[33] && prdata !== e[31:0]))
                    fail("bus response differs");
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int ns;
        int na;
        logic [7:0] hit;
        void'($urandom(33457));
        for (int k = 0; k < 5; k++) begin
            power_up(4'(k));
            rd(aux_status_pkg::ADDR_CASSETTE, cas_exp());
            if (k inside {[1:3]}) begin
                @(posedge pclk);
                cas_protect <= ~cas_protect;
                repeat (6) @(posedge pclk);
                rd(aux_status_pkg::ADDR_CASSETTE, cas_exp());
            end
        end
        strobe(0, 3);
        rd(aux_status_pkg::ADDR_SERIAL_RX, 32'h0);
        wr(aux_status_pkg::ADDR_PORT_CTRL, 32'h0000000a, 1'b0);
        ns = 10 + int'($urandom % 90);
        strobe(0, ns);
        rd(aux_status_pkg::ADDR_SERIAL_RX, {16'h0, bcd(ns)});
        chk_irq(1'b0);
        rd(aux_status_pkg::ADDR_IRQ_STATUS, 32'h1);
        wr(aux_status_pkg::ADDR_IRQ_MASK, 32'h1, 1'b0);
        chk_irq(1'b1);
        wr(aux_status_pkg::ADDR_IRQ_STATUS, 32'h1, 1'b0);
        chk_irq(1'b0);
        na = 10 + int'($urandom % 90);
        strobe(1, na);
        rd(aux_status_pkg::ADDR_AUX_RX, {16'h0, bcd(na)});
        strobe(2, 1);
        rd(aux_status_pkg::ADDR_PORT_CTRL, 32'h0001000a);
        wr(aux_status_pkg::ADDR_PORT_CTRL, 32'h0000040a, 1'b0);
        rd(aux_status_pkg::ADDR_PORT_CTRL, 32'h0000000a);
        for (int p = 1; p >= 0; p--) begin
            hit = 8'($urandom) | 8'h01;
            @(posedge pclk);
            counter_range_hit <= hit;
            pulse_active <= 1'(p);
            repeat (2) @(posedge pclk);
            rd(aux_status_pkg::ADDR_RANGE,
               {16'h0, 1'(p), 7'h0, hit});
        end
        rd(aux_status_pkg::ADDR_IRQ_STATUS, 32'h1e);
        wr(aux_status_pkg::ADDR_IRQ_MASK, 32'h1e, 1'b0);
        chk_irq(1'b1);
        wr(aux_status_pkg::ADDR_SERIAL_RX, 32'hffff, 1'b1);
        rd(aux_status_pkg::ADDR_SERIAL_RX, {16'h0, bcd(ns)});
        apb(1'b0, 8'h50, 32'h0, {2'b11, 32'h0});
        give_verdict();
    end

    // A hang anywhere ends the run with a counted mismatch.
    initial begin
        #500us;
        fail("timeout");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
